// >>> pis_if.sv
// interface: synchronised and edge-detected bus lines between modules
`timescale 1ns/1ps
interface pis_if;
	logic scl_s; // synchronised clock level
	logic sda_s; // synchronised data level
	logic scl_rise; // one-cycle pulse on clock rising edge
	logic scl_fall; // one-cycle pulse on clock falling edge
	logic start_det; // one-cycle pulse on start or repeated start
	logic stop_det; // one-cycle pulse on stop
	modport src (output scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
	modport dst (input scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
endinterface

// >>> pis_master.sv
// model: bus master that clocks the target and moves bytes
`timescale 1ns/1ps
module pis_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_rel
);
	// lines released; the clock stands still between frames
	initial begin
		scl = 1'h1;
		sda_rel = 1'h1;
	end
	// 3+3 low and 6 high system clocks make a 48 ns bus clock
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// start or repeated start: data falls while clock high
	task automatic start();
		w(3);
		sda_rel <= 1'h1;
		w(3);
		scl <= 1'h1;
		w(6);
		sda_rel <= 1'h0;
		w(6);
		scl <= 1'h0;
	endtask
	// stop: data rises while clock high
	task automatic stop();
		w(3);
		sda_rel <= 1'h0;
		w(3);
		scl <= 1'h1;
		w(6);
		sda_rel <= 1'h1;
		w(6);
	endtask
	// one bit; data is only released or pulled low
	task automatic bit_x(input logic b, output logic r);
		w(3);
		sda_rel <= b;
		w(3);
		scl <= 1'h1;
		w(6);
		r = sda;
		scl <= 1'h0;
	endtask
	// byte out, msb first; ack when the target pulls low on the ninth clock
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'h1, r);
		ack = !r;
	endtask
	// byte in; a high nak ends the burst
	task automatic get(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'h1, d[i]);
		end
		bit_x(nak, r);
	endtask
endmodule

// >>> pis_pkg.sv
// package: constants and types for the serial register target
package pis_pkg;
	localparam logic [6:0] PIS_ADDR_MAIN_HI = 7'h48; // main address, option bit 1
	localparam logic [6:0] PIS_ADDR_MAIN_LO = 7'h40; // main address, option bit 0
	localparam logic [6:0] PIS_ADDR_TEST = 7'h49; // test address, only when unlocked
	localparam logic PIS_DIR_READ = 1'h1; // direction bit value for read
	localparam logic [3:0] PIS_BIT_LAST = 4'h7; // last bit index of a byte
	localparam logic [3:0] PIS_BIT_ACK = 4'h8; // acknowledge slot index
	localparam logic [7:0] PIS_BYTE_ONE = 8'h01; // pointer step
	localparam logic [7:0] PIS_BYTE_ZERO = 8'h00; // pointer reset value
	localparam logic [3:0] PIS_CNT_ZERO = 4'h0; // bit counter reset value
	// pre-count after a start: the clock fall that closes the start wraps it to zero
	localparam logic [3:0] PIS_BIT_PRE = 4'hF;
	// bus target states
	typedef enum logic [2:0] {
		PIS_IDLE = 3'b000, // waiting for a start
		PIS_ADDR = 3'b001, // shifting the address byte
		PIS_REGA = 3'b010, // shifting the register address byte
		PIS_WDAT = 3'b011, // shifting a write data byte
		PIS_RDAT = 3'b100, // sending a read data byte
		PIS_IGN = 3'b101 // foreign address or nack, wait for stop/start
	} pis_state_t;
endpackage

// >>> pis_sync.sv
// module: pin synchroniser and bus condition detector
`timescale 1ns/1ps
module pis_sync
	import pis_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	pis_if.src bus
);
	logic [1:0] scl_sy_reg, scl_sy_next; // two-stage clock synchroniser
	logic [1:0] sda_sy_reg, sda_sy_next; // two-stage data synchroniser
	logic scl_d_reg, scl_d_next; // previous synchronised clock
	logic sda_d_reg, sda_d_next; // previous synchronised data

	// next values: first stage only feeds second stage
	always_comb begin
		scl_sy_next = {scl_sy_reg[0], scl_in};
		sda_sy_next = {sda_sy_reg[0], sda_in};
		scl_d_next = scl_sy_reg[1];
		sda_d_next = sda_sy_reg[1];
	end

	// idle bus lines float high, so reset to one
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_sy_reg <= 2'h3;
			sda_sy_reg <= 2'h3;
			scl_d_reg <= 1'h1;
			sda_d_reg <= 1'h1;
		end else if (ce) begin
			scl_sy_reg <= scl_sy_next;
			sda_sy_reg <= sda_sy_next;
			scl_d_reg <= scl_d_next;
			sda_d_reg <= sda_d_next;
		end
	end

	// edge and condition decode, gated by enable so pulses do not repeat
	assign bus.scl_s = scl_sy_reg[1];
	assign bus.sda_s = sda_sy_reg[1];
	assign bus.scl_rise = ce & scl_sy_reg[1] & ~scl_d_reg;
	assign bus.scl_fall = ce & ~scl_sy_reg[1] & scl_d_reg;
	// data falls while clock high: start
	assign bus.start_det = ce & scl_sy_reg[1] & scl_d_reg & ~sda_sy_reg[1] & sda_d_reg;
	// data rises while clock high: stop
	assign bus.stop_det = ce & scl_sy_reg[1] & scl_d_reg & sda_sy_reg[1] & ~sda_d_reg;
endmodule

// >>> pis_target.sv
// module: two-wire register target with auto-incrementing pointer
`timescale 1ns/1ps
// Notes on behaviour
// R1: target only, never drives clock
// R2: any clock rate up to 3.4 MHz
// R3: two-wire bus, one data one clock
// R4: data only pulled low or released
// R5: 7-bit address plus direction bit
// R6: master opens each transfer with start
// R7: option bit picks 0x48 or 0x40
// R8: foreign addresses are never acknowledged
// R9: test address 0x49 only when unlocked
// R10: master uses main address for registers
// R11: 8-bit registers, 8-bit register address
// R12: write bursts increment the pointer
// R13: read bursts increment the pointer
// R14: accesses routed to internal blocks
// R15: acknowledge address, pointer, each written byte
// R16: read follows pointer until master nacks
module pis_target
	import pis_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_opt,
	input wire logic test_unlock,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	output logic test_sel
);
	pis_if bus(); // synchronised bus view

	// clock only sampled, never driven [R1] [R3]
	pis_sync u_sync (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.bus(bus)
	);

	pis_state_t state_reg, state_next; // protocol state
	logic [3:0] bit_reg, bit_next; // bit index within byte, 8 = ack slot
	logic [7:0] shift_reg, shift_next; // receive or transmit shifter
	logic [7:0] ptr_reg, ptr_next; // register pointer
	logic [7:0] wdata_reg, wdata_next; // captured write byte
	logic wr_reg, wr_next; // write strobe
	logic rd_reg, rd_next; // read strobe
	logic drive_reg, drive_next; // pulling data low
	logic ack_reg, ack_next; // this byte gets an acknowledge
	logic read_reg, read_next; // current transfer is a read
	logic test_reg, test_next; // current transfer used test address
	logic mack_reg, mack_next; // master acked last read byte

	// address match against main and, if unlocked, test address [R5]
	function automatic logic pis_match(input logic [6:0] a, input logic opt, input logic unl);
		logic [6:0] main;
		main = opt ? PIS_ADDR_MAIN_HI : PIS_ADDR_MAIN_LO; // [R7]
		pis_match = (a == main) | (unl & (a == PIS_ADDR_TEST)); // [R8] [R9]
	endfunction

	// protocol next-state, sampled on clock rises, changed on clock falls
	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		ptr_next = ptr_reg;
		wdata_next = wdata_reg;
		wr_next = 1'b0;
		rd_next = 1'b0;
		drive_next = drive_reg;
		ack_next = ack_reg;
		read_next = read_reg;
		test_next = test_reg;
		mack_next = mack_reg;
		if (bus.start_det) begin
			// start or repeated start always resyncs; pointer kept [R6] [R16]
			state_next = PIS_ADDR;
			// the fall ending the start carries no bit, so count from one below zero
			bit_next = PIS_BIT_PRE;
			drive_next = 1'b0;
		end else if (bus.stop_det) begin
			state_next = PIS_IDLE;
			drive_next = 1'b0;
		end else if (bus.scl_rise) begin
			// sample data on rising clock; rate set purely by edges [R2]
			if (bit_reg <= PIS_BIT_LAST) begin
				if (state_reg != PIS_RDAT) begin
					shift_next = {shift_reg[6:0], bus.sda_s};
				end
			end else begin
				// ack slot: in a read, master's level decides continuation
				mack_next = ~bus.sda_s; // [R16]
			end
		end else if (bus.scl_fall) begin
			case (state_reg)
				PIS_IDLE, PIS_IGN: begin
					drive_next = 1'b0;
				end
				PIS_ADDR, PIS_REGA, PIS_WDAT: begin
					if (bit_reg == PIS_BIT_LAST) begin
						bit_next = PIS_BIT_ACK;
						if (state_reg == PIS_ADDR) begin
							ack_next = pis_match(shift_reg[7:1], addr_opt, test_unlock);
							read_next = (shift_reg[0] == PIS_DIR_READ); // [R5]
							// test flag only for an address that is really answered [R9]
							test_next = test_unlock & (shift_reg[7:1] == PIS_ADDR_TEST);
						end else begin
							ack_next = 1'b1;
						end
						// pull low for acknowledge only [R4] [R15]
						drive_next = (state_reg == PIS_ADDR) ?
							pis_match(shift_reg[7:1], addr_opt, test_unlock) : 1'b1;
						if (state_reg == PIS_REGA) begin
							ptr_next = shift_reg; // [R11]
						end else if (state_reg == PIS_WDAT) begin
							wdata_next = shift_reg;
							wr_next = 1'b1; // [R14]
						end
					end else if (bit_reg == PIS_BIT_ACK) begin
						bit_next = PIS_CNT_ZERO;
						drive_next = 1'b0;
						if (!ack_reg) begin
							state_next = PIS_IGN; // foreign address stays silent [R8]
						end else if (state_reg == PIS_ADDR && read_reg) begin
							// load first read byte and drive its msb
							state_next = PIS_RDAT;
							shift_next = {reg_rdata[6:0], 1'b0};
							drive_next = ~reg_rdata[7]; // [R4]
							rd_next = 1'b1; // [R14]
						end else if (state_reg == PIS_ADDR) begin
							state_next = PIS_REGA;
						end else begin
							if (state_reg == PIS_WDAT) begin
								ptr_next = ptr_reg + PIS_BYTE_ONE; // [R12]
							end
							state_next = PIS_WDAT;
						end
					end else begin
						bit_next = bit_reg + 4'h1;
					end
				end
				PIS_RDAT: begin
					if (bit_reg == PIS_BIT_LAST) begin
						// release for master ack; advance pointer [R13]
						bit_next = PIS_BIT_ACK;
						drive_next = 1'b0;
						ptr_next = ptr_reg + PIS_BYTE_ONE;
					end else if (bit_reg == PIS_BIT_ACK) begin
						bit_next = PIS_CNT_ZERO;
						if (mack_reg) begin
							// master wants more: next register [R13] [R16]
							shift_next = {reg_rdata[6:0], 1'b0};
							drive_next = ~reg_rdata[7];
							rd_next = 1'b1;
						end else begin
							state_next = PIS_IGN; // nack ends read [R16]
							drive_next = 1'b0;
						end
					end else begin
						bit_next = bit_reg + 4'h1;
						drive_next = ~shift_reg[7];
						shift_next = {shift_reg[6:0], 1'b0};
					end
				end
				default: begin
					state_next = PIS_IDLE;
					drive_next = 1'b0;
				end
			endcase
		end
	end

	// protocol state registers; enable low freezes everything
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= PIS_IDLE;
			bit_reg <= PIS_CNT_ZERO;
			shift_reg <= PIS_BYTE_ZERO;
			ptr_reg <= PIS_BYTE_ZERO;
			wdata_reg <= PIS_BYTE_ZERO;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			drive_reg <= 1'b0;
			ack_reg <= 1'b0;
			read_reg <= 1'b0;
			test_reg <= 1'b0;
			mack_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			ptr_reg <= ptr_next;
			wdata_reg <= wdata_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			drive_reg <= drive_next;
			ack_reg <= ack_next;
			read_reg <= read_next;
			test_reg <= test_next;
			mack_reg <= mack_next;
		end
	end

	// open drain: output held low, enable pulls the line [R4]
	assign sda_out = 1'b0;
	assign sda_oe = drive_reg;
	// register port toward internal blocks [R14]
	assign reg_addr = ptr_reg;
	assign reg_wdata = wdata_reg;
	assign reg_wr = wr_reg;
	assign reg_rd = rd_reg;
	// tells internal blocks the test address is in use; ordinary access uses main [R10]
	assign test_sel = test_reg;
endmodule

// >>> pis_target_checker.sv
// checker: port relations of the serial register target
`timescale 1ns/1ps
module pis_target_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic addr_opt,
	input wire logic test_unlock,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic test_sel
);
	logic [7:0] wp_reg; // pointer at last write
	logic [7:0] rp_reg; // pointer at last read load
	logic [7:0] wp_next;
	logic [7:0] rp_next;
	// keep the pointer of the last access so its later step can be judged
	always_comb begin
		wp_next = reg_wr ? reg_addr : wp_reg;
		rp_next = reg_rd ? reg_addr : rp_reg;
	end
	// register the held pointers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wp_reg <= 8'h00;
			rp_reg <= 8'h00;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_low; !sda_out; endproperty
	a_low: assert property (p_low) else $error("data driven high");
	property p_quiet; scl_in |=> $stable(sda_oe); endproperty
	a_quiet: assert property (p_quiet) else $error("data moved in clock high");
	property p_ack; reg_wr |-> ##[0:2] sda_oe; endproperty
	a_ack: assert property (p_ack) else $error("write byte not acked");
	property p_wr1; reg_wr |=> !reg_wr; endproperty
	a_wr1: assert property (p_wr1) else $error("write pulse too long");
	property p_rd1; reg_rd |=> !reg_rd; endproperty
	a_rd1: assert property (p_rd1) else $error("read pulse too long");
	property p_wstep; reg_wr |=> ##[0:40] (reg_addr == wp_reg + 8'h01); endproperty
	a_wstep: assert property (p_wstep) else $error("no step after write");
	property p_rstep; reg_rd |=> ##[0:120] (reg_addr == rp_reg + 8'h01); endproperty
	a_rstep: assert property (p_rstep) else $error("no step after read");
	property p_test; $rose(test_sel) |-> test_unlock; endproperty
	a_test: assert property (p_test) else $error("test address while locked");
endmodule
bind pis_target pis_target_checker u_pis_target_checker (.clk, .resetn, .ce, .scl_in,
	.sda_in, .sda_out, .sda_oe, .addr_opt, .test_unlock, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .test_sel);

// >>> pis_target_test.sv
// testbench: drives the target through the bus master model
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module pis_target_test;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic addr_opt = 1'h1; // main address 0x48
	logic test_unlock = 1'h0;
	logic scl_in, sda_rel, sda_out, sda_oe, reg_wr, reg_rd, test_sel, ack, exp;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [7:0] wa[$], wd[$]; // logged writes
	logic [6:0] probe[4] = '{7'h40, 7'h48, 7'h49, 7'h41};
	int errors = 0;
	int total_checks = 0;
	int rd_n = 0; // read loads seen
	// open drain data line with pull-up; target drives its data value when enabled
	wire logic sda_in = sda_rel & (!sda_oe | sda_out);
	// internal blocks answer with a pattern of the pointer
	assign reg_rdata = reg_addr ^ 8'hA5;
	pis_target u_pis_target (.clk, .resetn, .ce(1'h1), .scl_in, .sda_in, .sda_out, .sda_oe,
		.addr_opt, .test_unlock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .test_sel);
	pis_master u_pis_master (.clk, .sda(sda_in), .scl(scl_in), .sda_rel);
	initial begin
		forever #2 clk = !clk;
	end
	// log every write handed to the internal blocks
	always @(posedge clk) begin
		if (reg_wr) begin
			wa.push_back(reg_addr);
			wd.push_back(reg_wdata);
		end
		if (reg_rd) begin
			rd_n++;
		end
	end
	// verdict
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// three byte write burst from pointer 0x10
	task automatic t_write();
		u_pis_master.start();
		u_pis_master.put(8'h90, ack);
		`CHK(ack, 1'h1)
		u_pis_master.put(8'h10, ack);
		`CHK(ack, 1'h1)
		for (int i = 0; i < 3; i++) begin
			u_pis_master.put(8'h3C + 8'(i), ack);
			`CHK(ack, 1'h1)
		end
		u_pis_master.stop();
		`CHK(wa.size(), 3)
		for (int i = 0; i < 3; i++) begin
			`CHK(wa[i], 8'h10 + 8'(i))
			`CHK(wd[i], 8'h3C + 8'(i))
		end
		$display("test write done");
	endtask
	// pointer write, repeated start, three byte read ended by nak
	task automatic t_read();
		u_pis_master.start();
		u_pis_master.put(8'h90, ack);
		u_pis_master.put(8'h20, ack);
		u_pis_master.start();
		u_pis_master.put(8'h91, ack);
		`CHK(ack, 1'h1)
		for (int i = 0; i < 3; i++) begin
			u_pis_master.get(i == 2, d);
			`CHK(d, (8'h20 + 8'(i)) ^ 8'hA5)
		end
		u_pis_master.stop();
		`CHK(reg_addr, 8'h23)
		`CHK(rd_n, 3)
		$display("test read done");
	endtask
	// every option and lock state against main, test and foreign addresses
	task automatic t_addr();
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			addr_opt <= k[3];
			test_unlock <= k[2];
			exp = (probe[k % 4] == (k[3] ? 7'h48 : 7'h40)) || (k[2] && probe[k % 4] == 7'h49);
			u_pis_master.start();
			u_pis_master.put({probe[k % 4], 1'h0}, ack);
			u_pis_master.stop();
			`CHK(ack, exp)
			`CHK(test_sel, exp && (probe[k % 4] == 7'h49))
		end
		$display("test address done");
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'h1;
		repeat (5) @(posedge clk);
		`CHK(reg_addr, 8'h00)
		t_write();
		t_read();
		t_addr();
		end_sim();
	end
	// watchdog: the tests need about 4000 clocks
	initial begin
		#100000;
		errors++;
		$display("[FAIL] %0t watchdog", $time);
		end_sim();
	end
endmodule
